// ===== logic/hbp_pkg.sv
// shared constants for the host bus pin interface
package hbp_pkg;
    // ************************************************************
    // bus modes and speed codes
    // ************************************************************
    typedef enum logic [1:0] {hbp_mode_sync, hbp_mode_async, hbp_mode_burst} hbp_mode_e;
    localparam logic [1:0] SPEED_25MHZ = 2'h3;
    localparam logic [1:0] SPEED_125MHZ = 2'h0;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_PERIOD_NS = 25;
    localparam int SK_SLOW_PERIOD_NS = 4000;
    localparam int SK_FAST_PERIOD_NS = 800;
    // half periods in mclk cycles, rounded down, at least one
    localparam int SK_SLOW_HALF = (SK_SLOW_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int SK_FAST_HALF = (SK_FAST_PERIOD_NS / 2) / CLK_PERIOD_NS;
    localparam int SK_CNT_W = 8;
    // ************************************************************
    // widths and reset values
    // ************************************************************
    localparam int ADDR_W = 15;
    localparam int DATA_W = 32;
    localparam int PROM_BITS = 16;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0000_0000;
endpackage

// ===== logic/hbp_if.sv
// interface joining host and device ends of the host bus port
`timescale 1ns/1ps
interface hbp_if;
    import hbp_pkg::*;
    logic [ADDR_W-1:0] host_address_bits;
    logic addr_qualifier_n;
    logic addr_latch_strobe_n;
    logic command_cycle_qualifier_n;
    logic sync_direction;
    logic write_strobe_n;
    logic read_strobe_n;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic async_cycle_extend_out;
    logic sync_ready_n;
    logic chip_sleep_n;
    modport device (
        input host_address_bits, addr_qualifier_n, addr_latch_strobe_n, command_cycle_qualifier_n,
        input sync_direction, write_strobe_n, read_strobe_n, wdata, chip_sleep_n,
        output rdata, async_cycle_extend_out, sync_ready_n
    );
    modport host (
        output host_address_bits, addr_qualifier_n, addr_latch_strobe_n, command_cycle_qualifier_n,
        output sync_direction, write_strobe_n, read_strobe_n, wdata, chip_sleep_n,
        input rdata, async_cycle_extend_out, sync_ready_n
    );
endinterface

// ===== logic/hbp_device.sv
// device end of the host bus port with strap capture and prom load
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module hbp_device #(
    parameter int WAIT_CYCLES = 2,
    parameter bit WIDE_32 = 1'b1,
    parameter logic [hbp_pkg::ADDR_W-1:0] BASE_ADDR = 15'h0000,
    parameter logic [hbp_pkg::ADDR_W-1:0] BASE_MASK = 15'h7ff0
) (
    input wire logic mclk,
    input wire logic arst_n,
    hbp_if.device bus,
    input wire logic sync_mode_strap_n,
    input wire logic prom_enable_strap,
    input wire logic prom_serial_in_width_strap,
    input wire logic burst_select,
    input wire logic [1:0] onchip_bus_speed_field,
    output logic prom_serial_clock,
    output logic prom_serial_out,
    output logic prom_select,
    output logic prom_done_q,
    output logic [hbp_pkg::PROM_BITS-1:0] prom_word_q,
    output logic [1:0] bus_mode_q,
    output logic width_16_q,
    output logic prom_used_q,
    output logic sleeping_q,
    output logic [hbp_pkg::DATA_W-1:0] data_reg_q,
    output logic access_hit_q
);
    import hbp_pkg::*;
    if (WAIT_CYCLES < 1 || WAIT_CYCLES > 255) begin : g_bad_wait
        $error("bad WAIT_CYCLES");
    end
    if (SK_FAST_HALF < 1 || SK_SLOW_HALF > 255) begin : g_bad_half
        $error("prom clock divider out of range");
    end
    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int NSYNC = 9;
    logic [NSYNC-1:0] raw, s1_q, s2_q;
    assign raw = {sync_mode_strap_n, prom_enable_strap, prom_serial_in_width_strap, bus.addr_latch_strobe_n,
                  bus.command_cycle_qualifier_n, bus.write_strobe_n, bus.read_strobe_n, bus.chip_sleep_n,
                  burst_select};
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q <= 9'h03e;
            s2_q <= 9'h03e;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
        end
    end
    logic mode_s, en_s, din_s, ads_s, cyc_s, wr_s, rd_s, slp_s, brst_s;
    assign {mode_s, en_s, din_s, ads_s, cyc_s, wr_s, rd_s, slp_s, brst_s} = s2_q;
    // ************************************************************
    // strap capture
    // ************************************************************
    logic captured_q;
    logic [1:0] settle_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            captured_q <= 1'b0;
            settle_q <= 2'h0;
            bus_mode_q <= 2'h0;
            prom_used_q <= 1'b0;
            width_16_q <= 1'b0;
        end else if (!captured_q) begin
            // wait for the strap synchronisers to fill
            settle_q <= settle_q + 2'h1;
            if (settle_q == 2'h2) begin
                captured_q <= 1'b1;
                if (!mode_s) begin
                    bus_mode_q <= hbp_mode_sync;
                end else begin
                    bus_mode_q <= (WIDE_32 && brst_s) ? hbp_mode_burst : hbp_mode_async;
                end
                prom_used_q <= en_s;
                width_16_q <= !en_s && !WIDE_32 && din_s;
            end
        end
    end
    // ************************************************************
    // power-down
    // ************************************************************
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sleeping_q <= 1'b0;
        end else begin
            sleeping_q <= !slp_s;
        end
    end
    // ************************************************************
    // address latch and decode
    // ************************************************************
    logic ads_prev_q, aen_lat_q;
    logic [ADDR_W-1:0] addr_lat_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ads_prev_q <= 1'b1;
            addr_lat_q <= ADDR_RST;
            aen_lat_q <= 1'b1;
        end else begin
            ads_prev_q <= ads_s;
            if (ads_s && !ads_prev_q) begin
                addr_lat_q <= bus.host_address_bits;
                aen_lat_q <= bus.addr_qualifier_n;
            end
        end
    end
    logic hit;
    assign hit = !aen_lat_q && ((addr_lat_q & BASE_MASK) == (BASE_ADDR & BASE_MASK));
    // ************************************************************
    // access engine
    // ************************************************************
    typedef enum logic [1:0] {st_idle, st_wait, st_done} hbp_acc_e;
    hbp_acc_e st_q;
    logic [7:0] wcnt_q;
    logic is_wr_q;
    logic req;
    logic req_wr;
    always_comb begin
        req = 1'b0;
        req_wr = 1'b0;
        case (bus_mode_q)
            hbp_mode_async: begin
                req = !wr_s || !rd_s;
                req_wr = !wr_s;
            end
            hbp_mode_burst: begin
                req = !wr_s || !rd_s;
                req_wr = !cyc_s;
            end
            default: begin
                req = !cyc_s;
                req_wr = bus.sync_direction;
            end
        endcase
    end
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= st_idle;
            wcnt_q <= 8'h00;
            is_wr_q <= 1'b0;
            data_reg_q <= DATA_RST;
            access_hit_q <= 1'b0;
            bus.rdata <= DATA_RST;
            bus.async_cycle_extend_out <= 1'b1;
            bus.sync_ready_n <= 1'b1;
        end else begin
            case (st_q)
                st_idle: begin
                    bus.sync_ready_n <= 1'b1;
                    bus.async_cycle_extend_out <= 1'b1;
                    if (req && hit && !sleeping_q && captured_q) begin
                        st_q <= st_wait;
                        is_wr_q <= req_wr;
                        wcnt_q <= WAIT_CYCLES[7:0];
                        access_hit_q <= 1'b1;
                        bus.async_cycle_extend_out <= 1'b0;
                        if (bus_mode_q == hbp_mode_burst) begin
                            bus.sync_ready_n <= 1'b0;
                        end
                    end
                end
                st_wait: begin
                    if (wcnt_q == 8'h01) begin
                        st_q <= st_done;
                        if (is_wr_q) begin
                            data_reg_q <= bus.wdata;
                        end else begin
                            bus.rdata <= data_reg_q;
                        end
                        bus.async_cycle_extend_out <= 1'b1;
                        bus.sync_ready_n <= (bus_mode_q == hbp_mode_sync) ? 1'b0 : 1'b1;
                    end else begin
                        wcnt_q <= wcnt_q - 8'h01;
                    end
                end
                st_done: begin
                    bus.sync_ready_n <= 1'b1;
                    if (!req) begin
                        st_q <= st_idle;
                        access_hit_q <= 1'b0;
                    end
                end
                default: st_q <= st_idle;
            endcase
        end
    end
    // ************************************************************
    // prom loader
    // ************************************************************
    typedef enum logic [1:0] {pr_idle, pr_shift, pr_end} hbp_prom_e;
    hbp_prom_e pr_q;
    logic [SK_CNT_W-1:0] skc_q, half;
    logic [4:0] bit_q;
    logic sk_q;
    assign half = (onchip_bus_speed_field == SPEED_25MHZ) ? SK_SLOW_HALF[SK_CNT_W-1:0] :
                  SK_FAST_HALF[SK_CNT_W-1:0];
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pr_q <= pr_idle;
            skc_q <= '0;
            bit_q <= 5'h00;
            sk_q <= 1'b0;
            prom_serial_clock <= 1'b0;
            prom_serial_out <= 1'b0;
            prom_select <= 1'b0;
            prom_done_q <= 1'b0;
            prom_word_q <= '0;
        end else begin
            case (pr_q)
                pr_idle: begin
                    if (captured_q && prom_used_q && !prom_done_q) begin
                        pr_q <= pr_shift;
                        prom_select <= 1'b1;
                        skc_q <= half;
                        bit_q <= 5'h00;
                    end
                end
                pr_shift: begin
                    if (skc_q <= 8'h01) begin
                        skc_q <= half;
                        sk_q <= !sk_q;
                        prom_serial_clock <= !sk_q;
                        if (!sk_q) begin
                            prom_word_q <= {prom_word_q[PROM_BITS-2:0], din_s};
                            bit_q <= bit_q + 5'h01;
                        end else begin
                            prom_serial_out <= 1'b1;
                            if (bit_q == 5'(PROM_BITS)) begin
                                pr_q <= pr_end;
                            end
                        end
                    end else begin
                        skc_q <= skc_q - 8'h01;
                    end
                end
                pr_end: begin
                    prom_select <= 1'b0;
                    prom_serial_out <= 1'b0;
                    prom_done_q <= 1'b1;
                    pr_q <= pr_idle;
                end
                default: pr_q <= pr_idle;
            endcase
        end
    end
endmodule

// ===== logic/hbp_host.sv
// host end of the host bus port
`timescale 1ns/1ps
module hbp_host (
    input wire logic mclk,
    input wire logic arst_n,
    hbp_if.host bus,
    input wire logic [1:0] mode,
    input wire logic sleep_req,
    input wire logic [hbp_pkg::ADDR_W-1:0] addr,
    input wire logic [hbp_pkg::DATA_W-1:0] wdata,
    input wire logic wr_req,
    input wire logic rd_req,
    output logic busy_q,
    output logic done_q,
    output logic [hbp_pkg::DATA_W-1:0] rdata_q
);
    import hbp_pkg::*;
    typedef enum logic [2:0] {h_idle, h_addr, h_cmd, h_wait, h_end} hbp_host_e;
    hbp_host_e st_q;
    logic wr_q;
    logic [2:0] ready_s_q, ext_s_q;
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ready_s_q <= 3'h7;
            ext_s_q <= 3'h7;
        end else begin
            ready_s_q <= {ready_s_q[1:0], bus.sync_ready_n};
            ext_s_q <= {ext_s_q[1:0], bus.async_cycle_extend_out};
        end
    end
    logic ready_fell;
    assign ready_fell = ready_s_q[2] && !ready_s_q[1];
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= h_idle;
            wr_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            rdata_q <= DATA_RST;
            bus.host_address_bits <= ADDR_RST;
            bus.addr_qualifier_n <= 1'b1;
            bus.addr_latch_strobe_n <= 1'b1;
            bus.command_cycle_qualifier_n <= 1'b1;
            bus.sync_direction <= 1'b0;
            bus.write_strobe_n <= 1'b1;
            bus.read_strobe_n <= 1'b1;
            bus.wdata <= DATA_RST;
            bus.chip_sleep_n <= 1'b1;
        end else begin
            done_q <= 1'b0;
            bus.chip_sleep_n <= !sleep_req;
            case (st_q)
                h_idle: begin
                    if (wr_req || rd_req) begin
                        st_q <= h_addr;
                        busy_q <= 1'b1;
                        wr_q <= wr_req;
                        bus.host_address_bits <= addr;
                        bus.wdata <= wdata;
                        bus.addr_qualifier_n <= 1'b0;
                        bus.addr_latch_strobe_n <= 1'b0;
                        bus.sync_direction <= wr_req;
                    end
                end
                h_addr: begin
                    bus.addr_latch_strobe_n <= 1'b1;
                    st_q <= h_cmd;
                end
                h_cmd: begin
                    st_q <= h_wait;
                    case (mode)
                        hbp_mode_async: begin
                            bus.write_strobe_n <= !wr_q;
                            bus.read_strobe_n <= wr_q;
                        end
                        hbp_mode_burst: begin
                            bus.command_cycle_qualifier_n <= !wr_q;
                            bus.write_strobe_n <= !wr_q;
                            bus.read_strobe_n <= wr_q;
                        end
                        default: bus.command_cycle_qualifier_n <= 1'b0;
                    endcase
                end
                h_wait: begin
                    if ((mode == hbp_mode_sync) ? ready_fell : (ext_s_q[2] == 1'b0 && ext_s_q[1] == 1'b1)) begin
                        st_q <= h_end;
                    end
                end
                h_end: begin
                    st_q <= h_idle;
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                    if (!wr_q) begin
                        rdata_q <= bus.rdata;
                    end
                    bus.addr_qualifier_n <= 1'b1;
                    bus.command_cycle_qualifier_n <= 1'b1;
                    bus.write_strobe_n <= 1'b1;
                    bus.read_strobe_n <= 1'b1;
                end
                default: st_q <= h_idle;
            endcase
        end
    end
endmodule

// ===== testbench/hbp_checker.sv
// assertions on the wires joining host and device ends
`timescale 1ns/1ps
module hbp_checker #(
    parameter logic [hbp_pkg::ADDR_W-1:0] BASE_ADDR = 15'h0000,
    parameter logic [hbp_pkg::ADDR_W-1:0] BASE_MASK = 15'h7ff0
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [hbp_pkg::ADDR_W-1:0] host_address_bits,
    input wire logic addr_qualifier_n,
    input wire logic addr_latch_strobe_n,
    input wire logic command_cycle_qualifier_n,
    input wire logic sync_direction,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic [hbp_pkg::DATA_W-1:0] rdata,
    input wire logic async_cycle_extend_out,
    input wire logic sync_ready_n,
    input wire logic chip_sleep_n
);
    import hbp_pkg::*;
    localparam int ANS_MAX = 12;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    logic hit;
    assign hit = ((host_address_bits & BASE_MASK) == (BASE_ADDR & BASE_MASK)) && !addr_qualifier_n && chip_sleep_n;
    // ************************************************************
    // access steps
    // ************************************************************
    sequence sync_start_s;
        $fell(command_cycle_qualifier_n) && addr_latch_strobe_n && write_strobe_n && read_strobe_n && hit;
    endsequence
    sequence async_start_s;
        ($fell(write_strobe_n) || $fell(read_strobe_n)) && hit;
    endsequence
    sequence quiet_s;
        async_cycle_extend_out && sync_ready_n;
    endsequence
    // ************************************************************
    // checks
    // ************************************************************
    sync_answer_a: assert property (sync_start_s |-> ##[1:ANS_MAX] !sync_ready_n)
        else $error("sync access got no ready");
    sync_pulse_a: assert property ($fell(sync_ready_n) && write_strobe_n && read_strobe_n |=> sync_ready_n)
        else $error("sync ready low longer than one cycle");
    async_stretch_a: assert property (async_start_s |-> ##[1:6] !async_cycle_extend_out)
        else $error("async access not stretched");
    stretch_ends_a: assert property ($fell(async_cycle_extend_out) |-> ##[1:ANS_MAX] async_cycle_extend_out)
        else $error("async stretch never ended");
    miss_quiet_a: assert property ($rose(addr_latch_strobe_n) && !hit |=> quiet_s [*8])
        else $error("undecoded access answered");
    sleep_block_a: assert property ((!chip_sleep_n) [*4] ##0 quiet_s |=> quiet_s)
        else $error("answer while powered down");
    idle_quiet_a: assert property ((write_strobe_n && read_strobe_n && command_cycle_qualifier_n) [*4] |-> quiet_s)
        else $error("ready outputs active while idle");
    rdata_hold_a: assert property ((read_strobe_n && (command_cycle_qualifier_n || sync_direction)) [*4] |=> $stable(rdata))
        else $error("read data changed without a read");
endmodule

// ===== testbench/host_bus_pin_interface_bench.sv
// top-level bench joining host and device ends
`timescale 1ns/1ps
module host_bus_pin_interface_bench;
    import hbp_pkg::*;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic mode_strap_n = 1'b0;
    logic prom_en = 1'b0;
    logic width_strap = 1'b0;
    logic burst_sel = 1'b0;
    logic [1:0] speed = 2'h3;
    logic [1:0] mode = 2'h0;
    logic sleep_req = 1'b0;
    logic [ADDR_W-1:0] addr = 15'h0000;
    logic [DATA_W-1:0] wdata = 32'h0000_0000;
    logic wr_req = 1'b0;
    logic rd_req = 1'b0;
    logic sk, sdo, psel, pdone, w16, pused, sleeping, ahit, busy, done;
    logic [PROM_BITS-1:0] pword;
    logic [1:0] bus_mode;
    logic [DATA_W-1:0] dreg, rdata;
    int bad_count = 0;
    int num_checks = 0;
    hbp_if bus_if();
    always #12.5 mclk = ~mclk;
    hbp_device hbp_device_inst (.mclk(mclk), .arst_n(arst_n), .bus(bus_if.device), .sync_mode_strap_n(mode_strap_n),
        .prom_enable_strap(prom_en), .prom_serial_in_width_strap(width_strap), .burst_select(burst_sel),
        .onchip_bus_speed_field(speed), .prom_serial_clock(sk), .prom_serial_out(sdo), .prom_select(psel),
        .prom_done_q(pdone), .prom_word_q(pword), .bus_mode_q(bus_mode), .width_16_q(w16), .prom_used_q(pused),
        .sleeping_q(sleeping), .data_reg_q(dreg), .access_hit_q(ahit));
    hbp_host hbp_host_inst (.mclk(mclk), .arst_n(arst_n), .bus(bus_if.host), .mode(mode), .sleep_req(sleep_req),
        .addr(addr), .wdata(wdata), .wr_req(wr_req), .rd_req(rd_req), .busy_q(busy), .done_q(done), .rdata_q(rdata));
    hbp_checker hbp_checker_inst (.mclk(mclk), .arst_n(arst_n), .host_address_bits(bus_if.host_address_bits),
        .addr_qualifier_n(bus_if.addr_qualifier_n), .addr_latch_strobe_n(bus_if.addr_latch_strobe_n),
        .command_cycle_qualifier_n(bus_if.command_cycle_qualifier_n), .sync_direction(bus_if.sync_direction),
        .write_strobe_n(bus_if.write_strobe_n), .read_strobe_n(bus_if.read_strobe_n), .rdata(bus_if.rdata),
        .async_cycle_extend_out(bus_if.async_cycle_extend_out), .sync_ready_n(bus_if.sync_ready_n),
        .chip_sleep_n(bus_if.chip_sleep_n));
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_reset(input logic ms_n, input logic pe, input logic bs, input logic [1:0] spd);
        @(posedge mclk);
        mode_strap_n <= ms_n;
        prom_en <= pe;
        burst_sel <= bs;
        speed <= spd;
        arst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output bit got);
        int n;
        got = 1'b0;
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr_req <= wr;
        rd_req <= !wr;
        @(posedge mclk);
        wr_req <= 1'b0;
        rd_req <= 1'b0;
        for (n = 0; n < 40 && !got; n++) begin
            @(posedge mclk);
            if (done === 1'b1) got = 1'b1;
        end
        repeat (2) @(posedge mclk);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_modes();
        bit got;
        for (int m = 0; m < 3; m++) begin
            mode <= m[1:0];
            width_strap <= m[0];
            do_reset(m != 0, 1'b0, m == 2, SPEED_25MHZ);
            check("bus mode", 32'(bus_mode), 32'(m));
            check("width ignored", 32'(w16), 32'h0);
            access(1'b1, 15'h0004, 32'hc0de_0000 + 32'(m), got);
            check("write done", 32'(got), 32'h1);
            check("write data", dreg, 32'hc0de_0000 + 32'(m));
            access(1'b0, 15'h0008, 32'h0, got);
            check("read done", 32'(got), 32'h1);
            check("read data", rdata, 32'hc0de_0000 + 32'(m));
            mode_strap_n <= (m == 0);
            repeat (4) @(posedge mclk);
            check("mode kept", 32'(bus_mode), 32'(m));
        end
        $display("test modes done");
    endtask
    task automatic t_prom(input logic [1:0] spd, input int per);
        int c;
        width_strap <= 1'b1;
        do_reset(1'b0, 1'b1, 1'b0, spd);
        check("prom used", 32'(pused), 32'h1);
        for (c = 0; c < 500 && sk !== 1'b1; c++) @(posedge mclk);
        check("prom select", 32'(psel), 32'h1);
        for (c = 0; c < 500 && sk !== 1'b0; c++) @(posedge mclk);
        for (; c < 500 && sk !== 1'b1; c++) @(posedge mclk);
        check("prom clock period", 32'(c), 32'(per));
        check("prom data out", 32'(sdo), 32'h1);
        for (c = 0; c < 3000 && pdone !== 1'b1; c++) @(posedge mclk);
        check("prom word", 32'(pword), 32'h0000_ffff);
        check("prom released", 32'(psel), 32'h0);
        $display("test prom clock done");
    endtask
    task automatic t_prom_off();
        int moves;
        logic last;
        do_reset(1'b0, 1'b0, 1'b0, SPEED_125MHZ);
        check("prom unused", 32'(pused), 32'h0);
        moves = 0;
        last = sk;
        repeat (200) begin
            @(posedge mclk);
            if (sk !== last) moves++;
        end
        check("prom clock still", 32'(moves), 32'h0);
        $display("test prom off done");
    endtask
    task automatic t_refuse();
        bit got;
        mode <= 2'h0;
        do_reset(1'b0, 1'b0, 1'b0, SPEED_25MHZ);
        access(1'b1, 15'h0004, 32'h1111_2222, got);
        check("hit done", 32'(got), 32'h1);
        access(1'b1, 15'h0010, 32'h3333_4444, got);
        check("miss ignored", 32'(got), 32'h0);
        check("miss data", dreg, 32'h1111_2222);
        check("miss no hit", 32'(ahit), 32'h0);
        check("miss host waits", 32'(busy), 32'h1);
        do_reset(1'b0, 1'b0, 1'b0, SPEED_25MHZ);
        sleep_req <= 1'b1;
        repeat (6) @(posedge mclk);
        check("sleeping", 32'(sleeping), 32'h1);
        access(1'b1, 15'h0004, 32'h5555_6666, got);
        check("sleep ignored", 32'(got), 32'h0);
        check("sleep data", dreg, 32'h0);
        sleep_req <= 1'b0;
        do_reset(1'b0, 1'b0, 1'b0, SPEED_25MHZ);
        check("awake", 32'(sleeping), 32'h0);
        $display("test refusals done");
    endtask
    // ************************************************************
    // sequence and watchdog
    // ************************************************************
    initial begin
        t_modes();
        t_prom(SPEED_25MHZ, SK_SLOW_PERIOD_NS / CLK_PERIOD_NS);
        t_prom(SPEED_125MHZ, SK_FAST_PERIOD_NS / CLK_PERIOD_NS);
        t_prom_off();
        t_refuse();
        close_out();
    end
    initial begin
        repeat (60000) @(posedge mclk);
        bad_count++;
        $display("watchdog expired");
        close_out();
    end
endmodule
